// *** core/rqsb_regs.svh ***
// sideband field positions, register offsets and reset values
// assumes: included by the decoder and the sim files, by bare name
`ifndef RQSB_REGS_SVH
`define RQSB_REGS_SVH

// sideband bus layout, low bit of each field
`define RQSB_SB_W 137
`define RQSB_FBE_LO 0
`define RQSB_LBE_LO 8
`define RQSB_OFS_LO 16
`define RQSB_SOP_LO 20
`define RQSB_SOP0P_LO 22
`define RQSB_SOP1P_LO 24
`define RQSB_EOP_LO 26
`define RQSB_EOP0_LO 28
`define RQSB_EOP1_LO 32
`define RQSB_ABORT_BIT 36
`define RQSB_HINTP_LO 37
`define RQSB_HINTT_LO 39
`define RQSB_IND_LO 43
`define RQSB_STAG_LO 45
`define RQSB_SEQA_LO 61
`define RQSB_SEQB_LO 67
`define RQSB_PAR_LO 73

// start position codes
`define RQSB_LANE0 2'h0
`define RQSB_LANE32 2'h2

// register offsets
`define RQSB_CTRL_OFS 8'h00
`define RQSB_STAT_OFS 8'h04
`define RQSB_TAB_OFS 8'h08
`define RQSB_NULLCNT_OFS 8'h0C

// control bits and reset value
`define RQSB_CTRL_STRADDLE 0
`define RQSB_CTRL_PAREN 1
`define RQSB_CTRL_ALIGN128 2
`define RQSB_CTRL_ENDPOINT 3
`define RQSB_CTRL_RST 4'h0

// status bits, write one to clear
`define RQSB_STAT_ABORT 0
`define RQSB_STAT_PARITY 1
`define RQSB_STAT_FORBID 2
`define RQSB_STAT_RST 3'h0

// table write word: tag low byte, index above it
`define RQSB_TAB_IDX_LSB 8

`endif

// *** core/rqsb_pkg.sv ***
// types shared by the request sideband decoder
// assumes: compiled before every other design file
`default_nettype none

package rqsb_pkg;
    // two-bit start/end flag codes
    typedef enum logic [1:0] {
        RQSB_NONE = 2'b00,
        RQSB_ONE = 2'b01,
        RQSB_BAD = 2'b10,
        RQSB_TWO = 2'b11
    } rqsb_code_t;
    typedef logic [5:0] rqsb_seq_t;
    typedef logic [7:0] rqsb_tag_t;
    // packet slot in the beat: carried-over, first new, second new
    typedef logic [1:0] rqsb_slot_t;
endpackage

`default_nettype wire

// *** core/rqsb_tag_mem.sv ***
// steering tag table: one write port, two registered read ports
// assumes: single clock, writes from the register port
`default_nettype none

module rqsb_tag_mem #(
    parameter int AW = 6,
    parameter int DW = 8
) (
    // clock and control
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    // write side
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    // read side
    input wire logic [AW-1:0] rdAddrA,
    input wire logic [AW-1:0] rdAddrB,
    output logic [DW-1:0] rdDataA,
    output logic [DW-1:0] rdDataB
);
    logic [DW-1:0] mem [2**AW];

    // table storage, no reset needed
    always_ff @(posedge clk_sys) begin
        if (clkEn && wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // registered read data
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rdDataA <= '0;
            rdDataB <= '0;
        end else if (clkEn) begin
            rdDataA <= mem[rdAddrA];
            rdDataB <= mem[rdAddrB];
        end
    end
endmodule

`default_nettype wire

// *** core/rqsb_parity_chk.sv ***
// odd parity check of every payload byte against its parity bit
// assumes: data and parity are on the same clock as the caller
`default_nettype none

module rqsb_parity_chk #(
    parameter int BYTES = 64
) (
    // payload and parity
    input wire logic [8*BYTES-1:0] data,
    input wire logic [BYTES-1:0] parity,
    // result
    output logic mismatch
);
    logic [BYTES-1:0] byteBad;

    // each byte plus its bit must hold an odd number of ones
    genvar i;
    generate
        for (i = 0; i < BYTES; i++) begin : gByte
            assign byteBad[i] = ~(^{data[8*i +: 8], parity[i]});
        end
    endgenerate

    assign mismatch = |byteBad;
endmodule

`default_nettype wire

// *** core/rqsb_decoder.sv ***
// request sideband decoder: captures per-packet fields, tracks packets,
// aborts, parity, and returns order numbers
// assumes: request bus and register port on clk_sys, downstream ready
// comes from logic on the same clock
//
// How it works
// - trailing mask nibble passes through as the last-Dword byte mask.
// - per-packet fields are captured only on a start beat with handshake.
// - without straddle only bit 0 matters; last-beat marker delimits.
// - end offsets valid only while their end bit is set.
// - abort on a non-first beat nullifies that packet.
// - abort stays sticky for the rest of the packet.
// - endpoint mode reports an abort as an error message.
// - hint type pairs per packet, ignored without hint-present.
// - indirect bit selects table lookup of the steering tag.
// - order numbers return once the packet is fully accepted.
// - parity mismatch nullifies the packet and reports an error.
// - a beat moves only when valid and ready are both high.
// - under straddle, packets are delimited by start and end flags.
// - each returned number carries a one-cycle strobe.
//
// Strobed register access and the register offsets were chosen for this implementation.
`include "rqsb_regs.svh"
`default_nettype none

module rqsb_decoder #(
    parameter int TAB_AW = 6,
    parameter int BYTES = 64
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    // request stream from user logic
    input wire logic [8*BYTES-1:0] requestPayloadBus,
    input wire logic [`RQSB_SB_W-1:0] requestSidebandBus,
    input wire logic requestValid,
    input wire logic requestLast,
    output logic requestReady,
    // downstream pipeline can take a beat
    input wire logic txReady,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // decoded header fields of new packets
    output logic [1:0] hdrStrobe,
    output logic [7:0] hdrLeadMask,
    output logic [7:0] hdrTrailMask,
    output logic [1:0] hdrAddrOffset,
    output logic [1:0] hdrHintPresent,
    output logic [3:0] hdrHintType,
    output logic [15:0] hdrSteeringTag,
    // packet ends
    output logic [1:0] endStrobe,
    output logic [1:0] endNullify,
    output logic [3:0] endOffsetA,
    output logic [3:0] endOffsetB,
    // order number return
    output logic [5:0] orderNumberReturnA,
    output logic [5:0] orderNumberReturnB,
    output logic orderReturnStrobeA,
    output logic orderReturnStrobeB,
    // error reports
    output logic abortReport,
    output logic internalErrReport
);
    logic [3:0] ctrl_q;
    logic [2:0] stat_q;
    logic [15:0] nullCnt_q;
    logic openValid_q;
    logic openAbort_q;
    logic openErr_q;
    rqsb_pkg::rqsb_seq_t openSeq_q;
    logic [1:0] s1Start_q;
    logic [`RQSB_SB_W-1:0] s1Sb_q;
    logic [7:0] tagA;
    logic [7:0] tagB;
    logic parMismatch;

    // handshake and control decode
    wire beat = requestValid & requestReady;
    wire straddle = ctrl_q[`RQSB_CTRL_STRADDLE];
    wire parEn = ctrl_q[`RQSB_CTRL_PAREN];
    wire align128 = ctrl_q[`RQSB_CTRL_ALIGN128];
    wire endpoint = ctrl_q[`RQSB_CTRL_ENDPOINT];

    // sideband fields
    wire [1:0] sopCode = requestSidebandBus[`RQSB_SOP_LO +: 2];
    wire [1:0] eopCode = requestSidebandBus[`RQSB_EOP_LO +: 2];
    wire [1:0] sop0Pos = requestSidebandBus[`RQSB_SOP0P_LO +: 2];
    wire [1:0] sop1Pos = requestSidebandBus[`RQSB_SOP1P_LO +: 2];
    wire abortIn = requestSidebandBus[`RQSB_ABORT_BIT];
    wire [1:0] ind = requestSidebandBus[`RQSB_IND_LO +: 2];
    wire [15:0] stTag = requestSidebandBus[`RQSB_STAG_LO +: 16];
    wire [3:0] endOfsA = requestSidebandBus[`RQSB_EOP0_LO +: 4];
    wire [3:0] endOfsB = requestSidebandBus[`RQSB_EOP1_LO +: 4];
    wire [5:0] seqA = requestSidebandBus[`RQSB_SEQA_LO +: 6];
    wire [5:0] seqB = requestSidebandBus[`RQSB_SEQB_LO +: 6];
    wire [BYTES-1:0] parIn = requestSidebandBus[`RQSB_PAR_LO +: BYTES];

    // count of packets a flag code announces, 10 counts as none
    function automatic logic [1:0] codeCount(input logic [1:0] c);
        unique case (c)
            rqsb_pkg::RQSB_ONE: codeCount = 2'd1;
            rqsb_pkg::RQSB_TWO: codeCount = 2'd2;
            rqsb_pkg::RQSB_NONE: codeCount = 2'd0;
            rqsb_pkg::RQSB_BAD: codeCount = 2'd0;
        endcase
    endfunction

    // starts and ends in this beat
    wire [1:0] nStart = straddle ? codeCount(sopCode)
                                 : {1'b0, ~openValid_q};
    wire [1:0] nEndRaw = straddle ? codeCount(eopCode)
                                  : {1'b0, requestLast};
    wire [1:0] nItems = nStart + {1'b0, openValid_q};
    wire endTooMany = nEndRaw > nItems;
    wire [1:0] nEnd = endTooMany ? nItems : nEndRaw;

    // forbidden and reserved codes on an accepted beat
    wire badSop = straddle && sopCode == rqsb_pkg::RQSB_BAD;
    wire badEop = straddle && eopCode == rqsb_pkg::RQSB_BAD;
    wire badPos0 = nStart != 2'd0 && sop0Pos != `RQSB_LANE0
                   && sop0Pos != `RQSB_LANE32;
    wire badPos1 = nStart == 2'd2 && sop1Pos != `RQSB_LANE32;
    wire abortStart = straddle && abortIn && nStart != 2'd0
                      && nEnd != 2'd0;
    wire forbidSeen = beat & (badSop | badEop | badPos0 | badPos1
                              | endTooMany | abortStart);

    // parity only on accepted beats with checking on
    rqsb_parity_chk #(
        .BYTES(BYTES)
    ) uParity (
        .data(requestPayloadBus),
        .parity(parIn),
        .mismatch(parMismatch)
    );
    wire parErr = beat & parEn & parMismatch;

    // abort applies to the carried packet, never to a first beat
    wire abortNow = beat & abortIn & openValid_q;
    wire abortNew = abortNow & ~openAbort_q;

    // candidate packets: 0 carried, 1 first new, 2 second new
    wire [5:0] candSeq [3];
    wire candNull [3];
    assign candSeq[0] = openSeq_q;
    assign candSeq[1] = seqA;
    assign candSeq[2] = straddle ? seqB : seqA;
    assign candNull[0] = openAbort_q | abortIn | openErr_q | parErr;
    assign candNull[1] = parErr;
    assign candNull[2] = parErr;

    // slot of the k-th packet present in the beat
    wire [1:0] skip = {1'b0, ~openValid_q};
    wire [1:0] endIdA = skip;
    wire [1:0] endIdB = 2'd1 + skip;
    wire [1:0] keepId = nEnd + skip;
    wire keepOpen = nEnd < nItems;

    // control and status registers, status set wins over clear
    wire wrCtrl = regWr && regAddr == `RQSB_CTRL_OFS;
    wire wrStat = regWr && regAddr == `RQSB_STAT_OFS;
    wire wrTab = regWr && regAddr == `RQSB_TAB_OFS;
    wire [2:0] statSet = {forbidSeen, parErr, abortNew};
    wire [2:0] stat_d = (stat_q & ~(wrStat ? regWrData[2:0] : 3'h0))
                        | statSet;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_q <= `RQSB_CTRL_RST;
            stat_q <= `RQSB_STAT_RST;
        end else if (clkEn) begin
            if (wrCtrl) begin
                ctrl_q <= regWrData[3:0];
            end
            stat_q <= stat_d;
        end
    end

    // read data stand one cycle after the strobe, unmapped read zero
    wire [31:0] rdMux =
        regAddr == `RQSB_CTRL_OFS ? {28'h0, ctrl_q} :
        regAddr == `RQSB_STAT_OFS ? {29'h0, stat_q} :
        regAddr == `RQSB_NULLCNT_OFS ? {16'h0, nullCnt_q} : 32'h0;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            regRdData <= 32'h0;
        end else if (clkEn) begin
            regRdData <= regRd ? rdMux : 32'h0;
        end
    end

    // ready follows the downstream pipeline, one flop in between
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            requestReady <= 1'b0;
        end else if (clkEn) begin
            requestReady <= txReady;
        end
    end

    // carried packet state across beats
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            openValid_q <= 1'b0;
            openAbort_q <= 1'b0;
            openErr_q <= 1'b0;
            openSeq_q <= 6'h0;
        end else if (clkEn && beat) begin
            openValid_q <= keepOpen;
            openSeq_q <= candSeq[keepId];
            openAbort_q <= keepId == 2'd0 &&
                           (openAbort_q | abortIn);
            openErr_q <= (keepId == 2'd0 && openErr_q) | parErr;
        end
    end

    // packet ends, nullify and order number return
    wire endA = beat && nEnd != 2'd0;
    wire endB = beat && nEnd == 2'd2;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            endStrobe <= 2'b00;
            endNullify <= 2'b00;
            endOffsetA <= 4'h0;
            endOffsetB <= 4'h0;
            orderReturnStrobeA <= 1'b0;
            orderReturnStrobeB <= 1'b0;
            orderNumberReturnA <= 6'h0;
            orderNumberReturnB <= 6'h0;
        end else if (clkEn) begin
            endStrobe <= {endB, endA};
            endNullify <= {endB & candNull[endIdB],
                           endA & candNull[endIdA]};
            // offsets shown only with their end, zero otherwise
            endOffsetA <= endA ? endOfsA : 4'h0;
            endOffsetB <= endB ? endOfsB : 4'h0;
            orderReturnStrobeA <= endA;
            orderReturnStrobeB <= endB;
            orderNumberReturnA <= candSeq[endIdA];
            orderNumberReturnB <= candSeq[endIdB];
        end
    end

    // nullified packet counter and error reports
    wire [1:0] nNull = {1'b0, endA & candNull[endIdA]}
                       + {1'b0, endB & candNull[endIdB]};
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            nullCnt_q <= 16'h0;
            abortReport <= 1'b0;
            internalErrReport <= 1'b0;
        end else if (clkEn) begin
            nullCnt_q <= nullCnt_q + {14'h0, nNull};
            abortReport <= abortNew & endpoint;
            internalErrReport <= parErr;
        end
    end

    // first stage: sideband captured on start beats only
    wire [1:0] startMask = {nStart == 2'd2, nStart != 2'd0};
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s1Start_q <= 2'b00;
            s1Sb_q <= '0;
        end else if (clkEn) begin
            s1Start_q <= beat ? startMask : 2'b00;
            if (beat && nStart != 2'd0) begin
                s1Sb_q <= requestSidebandBus;
            end
        end
    end

    // table writes and lookups, index from low tag bits
    rqsb_tag_mem #(
        .AW(TAB_AW),
        .DW(8)
    ) uTagMem (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clkEn(clkEn),
        .wrEn(wrTab),
        .wrAddr(regWrData[`RQSB_TAB_IDX_LSB +: TAB_AW]),
        .wrData(regWrData[7:0]),
        .rdAddrA(stTag[TAB_AW-1:0]),
        .rdAddrB(stTag[8 +: TAB_AW]),
        .rdDataA(tagA),
        .rdDataB(tagB)
    );

    // second stage field selection
    wire [1:0] s1Hint = s1Sb_q[`RQSB_HINTP_LO +: 2];
    wire [1:0] s1Ind = s1Sb_q[`RQSB_IND_LO +: 2];
    wire [15:0] s1Tag = s1Sb_q[`RQSB_STAG_LO +: 16];
    wire [3:0] s1Type = s1Sb_q[`RQSB_HINTT_LO +: 4];
    wire [7:0] finTagA = !s1Hint[0] ? 8'h00 :
                         s1Ind[0] ? tagA : s1Tag[7:0];
    wire [7:0] finTagB = !s1Hint[1] ? 8'h00 :
                         s1Ind[1] ? tagB : s1Tag[15:8];
    wire [3:0] finType = {s1Hint[1] ? s1Type[3:2] : 2'b00,
                          s1Hint[0] ? s1Type[1:0] : 2'b00};
    wire [1:0] finOfs = align128 ?
                        s1Sb_q[`RQSB_OFS_LO +: 2] : 2'b00;

    // header outputs, masks passed through per packet nibble
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            hdrStrobe <= 2'b00;
            hdrLeadMask <= 8'h00;
            hdrTrailMask <= 8'h00;
            hdrAddrOffset <= 2'b00;
            hdrHintPresent <= 2'b00;
            hdrHintType <= 4'h0;
            hdrSteeringTag <= 16'h0000;
        end else if (clkEn) begin
            hdrStrobe <= s1Start_q;
            hdrLeadMask <= s1Sb_q[`RQSB_FBE_LO +: 8];
            hdrTrailMask <= s1Sb_q[`RQSB_LBE_LO +: 8];
            hdrAddrOffset <= finOfs;
            hdrHintPresent <= s1Hint;
            hdrHintType <= finType;
            hdrSteeringTag <= {finTagB, finTagA};
        end
    end
endmodule

`default_nettype wire

// *** sim/rqsb_decoder_properties.sv ***
// port checker for the request sideband decoder
// assumes: bound into rqsb_decoder, clkEn held high
`include "rqsb_regs.svh"
`default_nettype none

module rqsb_decoder_properties (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // request stream
    input wire logic [`RQSB_SB_W-1:0] requestSidebandBus,
    input wire logic requestValid,
    input wire logic requestReady,
    input wire logic txReady,
    // decoded outputs
    input wire logic [1:0] hdrStrobe,
    input wire logic [7:0] hdrLeadMask,
    input wire logic [7:0] hdrTrailMask,
    input wire logic [1:0] hdrHintPresent,
    input wire logic [3:0] hdrHintType,
    input wire logic [15:0] hdrSteeringTag,
    input wire logic [1:0] endStrobe,
    input wire logic [1:0] endNullify,
    input wire logic orderReturnStrobeA,
    input wire logic orderReturnStrobeB,
    input wire logic abortReport,
    input wire logic internalErrReport
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // beat taken at this edge
    wire logic took = requestValid && requestReady;

    end_after_beat_a: assert property (
        endStrobe != 2'h0 |-> $past(took))
        else $error("end without accepted beat");
    hdr_after_start_a: assert property (
        hdrStrobe != 2'h0 |-> $past(took, 2))
        else $error("header without accepted beat");
    byte_masks_a: assert property (
        hdrStrobe != 2'h0 |-> hdrLeadMask == $past(requestSidebandBus[7:0], 2)
            && hdrTrailMask == $past(requestSidebandBus[15:8], 2))
        else $error("byte masks differ from start beat");
    return_pairs_a: assert property (
        orderReturnStrobeA == endStrobe[0]
            && orderReturnStrobeB == endStrobe[1])
        else $error("return strobes differ from ends");
    null_with_end_a: assert property (
        (endNullify & ~endStrobe) == 2'h0)
        else $error("nullify without end");
    abort_cause_a: assert property (
        abortReport |-> $past(took && requestSidebandBus[`RQSB_ABORT_BIT]))
        else $error("abort report without abort beat");
    error_cause_a: assert property (
        internalErrReport |-> $past(took))
        else $error("parity report without beat");
    hint_gate_a: assert property (
        hdrStrobe[0] && !hdrHintPresent[0] |->
            hdrHintType[1:0] == 2'h0 && hdrSteeringTag[7:0] == 8'h00)
        else $error("hint fields without hint");
    ready_lag_a: assert property (
        $rose(txReady) |=> requestReady)
        else $error("ready did not follow");

    // main scenarios
    two_ends_c: cover property (endStrobe == 2'h3);
    abort_seen_c: cover property (abortReport);
    parity_seen_c: cover property (internalErrReport && endNullify != 2'h0);
endmodule

bind rqsb_decoder rqsb_decoder_properties props (.*);

`default_nettype wire

// *** sim/rqsb_user_model.sv ***
// user-side request source: offers beats, holds each until taken
// assumes: ready comes from the decoder on the same clock
`include "rqsb_regs.svh"
`default_nettype none

module rqsb_user_model (
    // clock
    input wire logic clk_sys,
    // request stream
    input wire logic requestReady,
    output logic requestValid,
    output logic requestLast,
    output logic [`RQSB_SB_W-1:0] requestSidebandBus,
    output logic [511:0] requestPayloadBus
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle at time zero
    initial begin
        requestValid = 1'b0;
        requestLast = 1'b0;
        requestSidebandBus = '0;
        requestPayloadBus = '0;
    end

    // offer one beat, optionally with a corrupted parity bit
    task automatic send_beat(input logic [`RQSB_SB_W-1:0] sb,
        input logic last, input logic bad, output bit ok);
        logic [511:0] pay;
        int n;
        pay = {4{sb[127:0]}};
        for (n = 0; n < 64; n++)
            sb[`RQSB_PAR_LO+n] = ~^pay[8*n+:8];
        sb[`RQSB_PAR_LO] = sb[`RQSB_PAR_LO] ^ bad;
        requestValid <= 1'b1;
        requestLast <= last;
        requestSidebandBus <= sb;
        requestPayloadBus <= pay;
        ok = 0;
        // hold beat and abort until ready is seen
        for (n = 0; n < 60 && !ok; n++) begin
            @(posedge clk_sys);
            ok = requestReady;
        end
    endtask

    // release: bus shows the inverse, not the last beat
    task automatic rest;
        requestValid <= 1'b0;
        requestLast <= ~requestLast;
        requestSidebandBus <= ~requestSidebandBus;
        requestPayloadBus <= ~requestPayloadBus;
    endtask
endmodule

`default_nettype wire

// *** sim/test_requester_request_sideband.sv ***
// self-checking bench for the request sideband decoder
// assumes: decoder, checker and user model compiled first
`include "rqsb_regs.svh"
`default_nettype none

module test_requester_request_sideband;
    timeunit 1ns;
    timeprecision 1ns;

    // clock, reset and ports
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    logic txReady = 1'b1;
    logic [511:0] requestPayloadBus;
    logic [`RQSB_SB_W-1:0] requestSidebandBus;
    logic requestValid, requestLast, requestReady;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData;
    logic regWr = 1'b0, regRd = 1'b0;
    logic [1:0] hdrStrobe, hdrAddrOffset, hdrHintPresent, endStrobe, endNullify;
    logic [7:0] hdrLeadMask, hdrTrailMask;
    logic [3:0] hdrHintType, endOffsetA, endOffsetB;
    logic [15:0] hdrSteeringTag;
    logic [5:0] orderNumberReturnA, orderNumberReturnB;
    logic orderReturnStrobeA, orderReturnStrobeB, abortReport, internalErrReport;
    int failures = 0, nCompared = 0, nAbort = 0, nErr = 0, nEnds = 0, k;

    always #20 clk_sys = ~clk_sys;

    rqsb_decoder dut (.*);
    rqsb_user_model user (.*);

    // pulse counters between checks
    always @(posedge clk_sys) begin
        if (abortReport === 1'b1) nAbort++;
        if (internalErrReport === 1'b1) nErr++;
        if (endStrobe[0] === 1'b1) nEnds++;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        nCompared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %0h, expected %0h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compared %0d, failures %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // sideband word; start lanes 0 and 32, end offsets fixed at F and 7
    function automatic logic [`RQSB_SB_W-1:0] mk(input logic [1:0] sop, eop,
        input logic abt, input logic [1:0] hp, input logic [3:0] ht,
        input logic [1:0] ind, input logic [15:0] tag,
        input logic [5:0] sqa, sqb, input logic [1:0] ofs, input logic [7:0] l);
        return {64'h0, sqb, sqa, tag, ind, ht, hp, abt, 4'h7, 4'hF, eop,
            2'h2, 2'h0, sop, 2'h0, ofs, l[3:0], l[7:4], l};
    endfunction

    function automatic logic [`RQSB_SB_W-1:0] mid(input logic [1:0] sop,
        eop, input logic abt);
        return mk(sop, eop, abt, 2'h0, 4'h0, 2'h0, 16'h0, 6'h0, 6'h0, 2'h0,
            8'h0);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        chk(regRdData, exp);
    endtask

    task automatic beat(input logic [`RQSB_SB_W-1:0] sb, input logic last,
        input logic bad);
        bit ok;
        user.send_beat(sb, last, bad, ok);
        if (!ok) begin
            failures++;
            tally_and_finish;
        end
    endtask

    task automatic ends_is(input logic [1:0] e, n, input logic [5:0] a, b);
        @(negedge clk_sys);
        chk(endStrobe, e);
        chk(endNullify, n);
        chk({orderReturnStrobeB, orderReturnStrobeA}, e);
        chk(endOffsetA, e[0] ? 4'hF : 4'h0);
        chk(endOffsetB, e[1] ? 4'h7 : 4'h0);
        if (e[0]) chk(orderNumberReturnA, a);
        if (e[1]) chk(orderNumberReturnB, b);
    endtask

    task automatic hdr_is(input logic [1:0] s, input logic [7:0] l,
        input logic [1:0] o, p, input logic [3:0] t, input logic [15:0] g);
        @(negedge clk_sys);
        chk(hdrStrobe, s);
        chk(hdrLeadMask, l);
        chk(hdrTrailMask, {l[3:0], l[7:4]});
        chk(hdrAddrOffset, o);
        chk(hdrHintPresent, p);
        chk(hdrHintType, t);
        chk(hdrSteeringTag, g);
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        // reset values and an unmapped place
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h10, 32'h0);
        // single beat in dword mode, hint fields dropped
        @(posedge clk_sys);
        beat(mk(2'h1, 2'h1, 0, 2'h0, 4'hF, 2'h3, 16'hABCD, 6'h05, 6'h00,
            2'h0, 8'hA5), 1, 0);
        user.rest();
        ends_is(2'h1, 2'h0, 6'h05, 6'h00);
        hdr_is(2'h1, 8'hA5, 2'h0, 2'h0, 4'h0, 16'h0);
        // aligned endpoint; abort dropped while stalled stays sticky
        wr(8'h00, 32'hC);
        @(posedge clk_sys);
        beat(mk(2'h1, 2'h0, 0, 2'h1, 4'h1, 2'h0, 16'h005A, 6'h11, 6'h00,
            2'h2, 8'h3C), 0, 0);
        txReady <= 1'b0;
        beat(mid(2'h0, 2'h0, 1), 0, 0);
        fork
            beat(mid(2'h0, 2'h0, 0), 1, 0);
            begin
                repeat (3) @(posedge clk_sys);
                txReady <= 1'b1;
            end
        join
        user.rest();
        ends_is(2'h1, 2'h1, 6'h11, 6'h00);
        hdr_is(2'h0, 8'h3C, 2'h2, 2'h1, 4'h1, 16'h005A);
        chk(nAbort, 1);
        rd(8'h04, 32'h1);
        rd(8'h0C, 32'h1);
        wr(8'h04, 32'h1);
        rd(8'h04, 32'h0);
        // steering tag through the lookup table
        wr(8'h08, 32'h3C7);
        @(posedge clk_sys);
        beat(mk(2'h1, 2'h1, 0, 2'h1, 4'h2, 2'h1, 16'hFF03, 6'h21, 6'h00,
            2'h1, 8'h0F), 1, 0);
        user.rest();
        ends_is(2'h1, 2'h0, 6'h21, 6'h00);
        hdr_is(2'h1, 8'h0F, 2'h1, 2'h1, 4'h2, 16'h00C7);
        // parity: a bad byte nullifies, idle and clean beats do not
        wr(8'h00, 32'h2);
        @(posedge clk_sys);
        beat(mk(2'h1, 2'h1, 0, 2'h0, 4'h0, 2'h0, 16'h0, 6'h2A, 6'h00,
            2'h0, 8'hFF), 1, 1);
        user.rest();
        ends_is(2'h1, 2'h1, 6'h2A, 6'h00);
        @(posedge clk_sys);
        beat(mk(2'h1, 2'h1, 0, 2'h0, 4'h0, 2'h0, 16'h0, 6'h2B, 6'h00,
            2'h0, 8'hFF), 1, 0);
        user.rest();
        ends_is(2'h1, 2'h0, 6'h2B, 6'h00);
        chk(nErr, 1);
        rd(8'h04, 32'h2);
        wr(8'h04, 32'h2);
        // straddle: two packets in one beat, last marker ignored
        wr(8'h00, 32'h1);
        @(posedge clk_sys);
        beat(mk(2'h3, 2'h3, 0, 2'h0, 4'h0, 2'h0, 16'h0, 6'h07, 6'h09,
            2'h0, 8'h96), 0, 0);
        user.rest();
        ends_is(2'h3, 2'h0, 6'h07, 6'h09);
        hdr_is(2'h3, 8'h96, 2'h0, 2'h0, 4'h0, 16'h0);
        k = nEnds;
        @(posedge clk_sys);
        beat(mk(2'h1, 2'h0, 0, 2'h0, 4'h0, 2'h0, 16'h0, 6'h03, 6'h00,
            2'h0, 8'h11), 1, 0);
        beat(mid(2'h0, 2'h1, 0), 0, 0);
        user.rest();
        ends_is(2'h1, 2'h0, 6'h03, 6'h00);
        chk(nEnds, k);
        // forbidden flag codes show in status
        @(posedge clk_sys);
        beat(mid(2'h2, 2'h2, 0), 0, 0);
        user.rest();
        rd(8'h04, 32'h4);
        tally_and_finish;
    end
endmodule

`default_nettype wire
